// *** logic/fsac_top.v ***
// Fault status, conversion setup and pin I/O control register bank with an APB slave.
`timescale 1ns/1ns
`include "fsac_map.vh"

// Summary of operation
// - Fault flags stay set until host writes one; writing zero keeps; bit 4 excluded.
// - Force bit is read-write, drives fault output while one, resets to zero.
// - Internal consistency check failure sets the internal-fault flag.
// - Power-on flag sets once defaults and OTP copy have been loaded.
// - A CRC mismatch in the last received packet sets the packet-error flag.
// - Summary undervoltage flag sets when any cell is below threshold; resets zero.
// - Summary overvoltage flag sets when any cell is above threshold; resets zero.
// - Per-cell overvoltage bits 0..5 name the cells that caused the flag.
// - Per-cell undervoltage bits 0..5 name the cells that caused the flag.
// - Parity results are read-only; second register upper four bits read zero.
// - Converter-on bit one keeps the converter powered all the time.
// - Otherwise power converter on request, wait for settling, power off after.
// - Two-bit field picks thermistor inputs: none, first, second or both.
// - Analog-input bit includes the general analog input in the next sequence.
// - Three-bit cell field value n selects cells one through n plus one.
// - Auxiliary bit one connects the auxiliary pin to the five volt regulator.
// - GPIO drive zero pulls the open-drain pin low; one releases it.
// - GPIO input bit reflects the pin level.
// - Low-power bit enters sleep and disables all protection comparators.
// - Leaving sleep waits 1 ms before protection monitoring resumes.
// - Thermistor-ground bits connect each input's negative side to ground.
module fsac_top #(
  // Cell count, then wake-up and settling times in clock cycles.
  parameter CELLS     = 6,
  parameter WAKE_CYC  = `FSAC_WAKE_US * `FSAC_CLK_MHZ,
  parameter SETTLE_CYC = `FSAC_SETTLE_US * `FSAC_CLK_MHZ
) (
  // Clock and reset.
  input  wire             pclk,
  input  wire             presetn,
  // APB slave.
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  input  wire [3:0]       pstrb,
  output wire             pready,
  output reg  [31:0]      prdata,
  output wire             pslverr,
  // Fault sources from the device core, all on pclk.
  input  wire [CELLS-1:0] cell_high_flags_in,
  input  wire [CELLS-1:0] cell_low_flags_in,
  input  wire             crc_error_pulse,
  input  wire             consistency_fail,
  input  wire             defaults_loaded,
  input  wire [7:0]       parity_first_in,
  input  wire [3:0]       parity_second_in,
  // Conversion control.
  input  wire             conv_request,
  input  wire             conv_done,
  output reg              conv_power,
  output wire             conv_go,
  output wire [1:0]       conv_thermistor_sel,
  output wire             conv_general_analog_sel,
  output wire [2:0]       conv_cell_sel,
  // Pins and power controls.
  output reg              fault_out,
  output wire             five_volt_regulator_aux,
  input  wire             gpio_in,
  output wire             gpio_out,
  output wire             gpio_oe,
  output wire             sleep_mode,
  output reg              comparators_enable,
  output wire [1:0]       thermistor_ground_switch
);

  // Converter sequencer states, one-hot.
  localparam [3:0] CV_OFF = 4'b0001;
  localparam [3:0] CV_SETTLE = 4'b0010;
  localparam [3:0] CV_RUN = 4'b0100;
  localparam [3:0] CV_HOLD = 4'b1000;

  // Register bank state, synchroniser and timers.
  reg [7:0]        fault_reg;
  wire [CELLS-1:0] ov_cells_flags;
  wire [CELLS-1:0] uv_cells_flags;
  reg [7:0]        conv_reg;
  reg [7:0]        pin_io_reg;
  reg              gpio_meta_reg;
  reg              gpio_sync_reg;
  reg              por_pending_reg;
  reg [3:0]        cv_state_reg;
  reg [3:0]        cv_state_next;
  reg [31:0]       settle_cnt_reg;
  reg [31:0]       wake_cnt_reg;
  reg              sleep_prev_reg;
  // Bus decode and gated comparator levels.
  wire             wr_en;
  wire             rd_en;
  wire [7:0]       wbyte;
  wire [CELLS-1:0] high_live;
  wire [CELLS-1:0] low_live;
  wire             cmp_live;
  wire             fault_wr;

  // Decode a byte address to a mapped register; index times four is the byte address.
  // The shift by two keeps each register on its own aligned word.
  function hit;
    input [11:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  // True for any address that holds a register of this bank.
  function mapped;
    input [11:0] addr;
    begin
      mapped = hit(addr, `FSAC_IDX_FAULT) | hit(addr, `FSAC_IDX_OV_CELLS) |
               hit(addr, `FSAC_IDX_UV_CELLS) | hit(addr, `FSAC_IDX_PAR_FIRST) |
               hit(addr, `FSAC_IDX_PAR_SEC) | hit(addr, `FSAC_IDX_CONV) |
               hit(addr, `FSAC_IDX_PIN_IO) | hit(addr, `FSAC_IDX_STATUS);
    end
  endfunction

  // Zero-wait slave: pready is tied high, so every access phase ends at its first edge.
  // Unmapped addresses answer with an error and have no effect on any register.
  // Writes use byte lane zero only; the upper lanes carry nothing in this bank.
  // Reads are decoded in the setup phase so prdata is settled before the access edge.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign wr_en = psel & penable & pwrite & pstrb[0] & mapped(paddr);
  assign rd_en = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];

  // Protection comparators are masked while asleep and during wake-up settling.
  // The sleep bit masks at once, because the enable flop only follows a cycle later.
  assign cmp_live = comparators_enable & ~pin_io_reg[`FSAC_IO_SLEEP];
  assign high_live = cmp_live ? cell_high_flags_in : {CELLS{1'b0}};
  assign low_live = cmp_live ? cell_low_flags_in : {CELLS{1'b0}};

  // GPIO pin is asynchronous, so it passes two flops before it is read.
  // Its reset value of zero lasts two cycles only and feeds no edge detector.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_meta_reg <= 1'b0;
      gpio_sync_reg <= 1'b0;
    end else begin
      gpio_meta_reg <= gpio_in;
      gpio_sync_reg <= gpio_meta_reg;
    end
  end

  // Sticky fault flags: a set in the same cycle as a clear wins, so no event is lost.
  // Bit 4 is the self-test force, a plain read-write bit and not a flag.
  // Bits 7 and 6 are not implemented and never set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reg <= `FSAC_FAULT_RST;
      por_pending_reg <= 1'b1;
    end else begin
      if (fault_wr) begin
        fault_reg[`FSAC_FLT_OV] <= fault_reg[`FSAC_FLT_OV] & ~wbyte[`FSAC_FLT_OV];
        fault_reg[`FSAC_FLT_UV] <= fault_reg[`FSAC_FLT_UV] & ~wbyte[`FSAC_FLT_UV];
        fault_reg[`FSAC_FLT_CRC] <= fault_reg[`FSAC_FLT_CRC] & ~wbyte[`FSAC_FLT_CRC];
        fault_reg[`FSAC_FLT_POR] <= fault_reg[`FSAC_FLT_POR] & ~wbyte[`FSAC_FLT_POR];
        fault_reg[`FSAC_FLT_IFAULT] <= fault_reg[`FSAC_FLT_IFAULT] & ~wbyte[`FSAC_FLT_IFAULT];
        fault_reg[`FSAC_FLT_FORCE] <= wbyte[`FSAC_FLT_FORCE];
      end
      if (|high_live) begin
        fault_reg[`FSAC_FLT_OV] <= 1'b1;
      end
      if (|low_live) begin
        fault_reg[`FSAC_FLT_UV] <= 1'b1;
      end
      if (crc_error_pulse) begin
        fault_reg[`FSAC_FLT_CRC] <= 1'b1;
      end
      if (consistency_fail) begin
        fault_reg[`FSAC_FLT_IFAULT] <= 1'b1;
      end
      // The power-on flag waits for the load to finish, then fires once.
      if (por_pending_reg && defaults_loaded) begin
        fault_reg[`FSAC_FLT_POR] <= 1'b1;
        por_pending_reg <= 1'b0;
      end
    end
  end

  // A write to the fault register is the clear strobe for the summaries and the cells.
  assign fault_wr = wr_en & hit(paddr, `FSAC_IDX_FAULT);

  // Per-cell flags follow the same write-one-to-clear rule as the summaries.
  // One slice per cell, so the bank follows CELLS; a live cell survives a clear.
  genvar cell_i;
  generate
    for (cell_i = 0; cell_i < CELLS; cell_i = cell_i + 1) begin : g_cell
      reg high_bit_reg;
      reg low_bit_reg;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          high_bit_reg <= 1'b0;
          low_bit_reg <= 1'b0;
        end else begin
          if (fault_wr && wbyte[`FSAC_FLT_OV]) begin
            high_bit_reg <= high_live[cell_i];
          end else if (high_live[cell_i]) begin
            high_bit_reg <= 1'b1;
          end
          if (fault_wr && wbyte[`FSAC_FLT_UV]) begin
            low_bit_reg <= low_live[cell_i];
          end else if (low_live[cell_i]) begin
            low_bit_reg <= 1'b1;
          end
        end
      end

      // Cell n plus one sits at bit n of its flag register.
      assign ov_cells_flags[cell_i] = high_bit_reg;
      assign uv_cells_flags[cell_i] = low_bit_reg;
    end
  endgenerate

  // Control registers; reserved bits are masked so they always read zero.
  // Writes with lane zero clear are dropped, so a partial write cannot corrupt a field.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_reg <= `FSAC_CONV_RST;
      pin_io_reg <= `FSAC_PIN_IO_RST;
    end else if (wr_en) begin
      if (hit(paddr, `FSAC_IDX_CONV)) begin
        conv_reg <= wbyte & `FSAC_CONV_MASK;
      end
      if (hit(paddr, `FSAC_IDX_PIN_IO)) begin
        pin_io_reg <= wbyte & `FSAC_PIN_IO_MASK;
      end
    end
  end

  // Fault output follows any sticky flag or the self-test force bit.
  // Registering it costs one cycle of latency but keeps the pin free of glitches.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_out <= 1'b0;
    end else begin
      fault_out <= |fault_reg[5:0];
    end
  end

  // Wake-up timer: comparators stay off until the reference has settled.
  // The count restarts whenever sleep is entered again, so a short wake is never trusted.
  // Limitation: cell events inside the window are not recorded at all.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_prev_reg <= 1'b0;
      wake_cnt_reg <= 32'h0000_0000;
      comparators_enable <= 1'b1;
    end else begin
      sleep_prev_reg <= pin_io_reg[`FSAC_IO_SLEEP];
      if (pin_io_reg[`FSAC_IO_SLEEP]) begin
        comparators_enable <= 1'b0;
        wake_cnt_reg <= 32'h0000_0000;
      end else if (sleep_prev_reg) begin
        wake_cnt_reg <= WAKE_CYC;
      end else if (wake_cnt_reg > 32'h0000_0001) begin
        wake_cnt_reg <= wake_cnt_reg - 32'h0000_0001;
      end else if (!comparators_enable) begin
        comparators_enable <= 1'b1;
        wake_cnt_reg <= 32'h0000_0000;
      end
    end
  end

  // Converter power sequencer: in auto mode power up, settle, run, then power down.
  // A request during a run is ignored, so the core must pace its requests.
  // In forced-on mode the hold state waits with power up for the next request.
  always @* begin
    cv_state_next = cv_state_reg;
    case (cv_state_reg)
      CV_OFF: begin
        if (conv_request) begin
          cv_state_next = conv_reg[`FSAC_CONV_ON] ? CV_RUN : CV_SETTLE;
        end
      end
      CV_SETTLE: begin
        if (settle_cnt_reg <= 32'h0000_0001) begin
          cv_state_next = CV_RUN;
        end
      end
      CV_RUN: begin
        if (conv_done) begin
          cv_state_next = conv_reg[`FSAC_CONV_ON] ? CV_HOLD : CV_OFF;
        end
      end
      CV_HOLD: begin
        if (!conv_reg[`FSAC_CONV_ON]) begin
          cv_state_next = CV_OFF;
        end else if (conv_request) begin
          cv_state_next = CV_RUN;
        end
      end
      default: cv_state_next = CV_OFF;
    endcase
  end

  // Sequencer state, settle counter and converter power.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cv_state_reg <= CV_OFF;
      settle_cnt_reg <= 32'h0000_0000;
      conv_power <= 1'b0;
    end else begin
      cv_state_reg <= cv_state_next;
      if (cv_state_reg == CV_OFF) begin
        settle_cnt_reg <= SETTLE_CYC;
      end else if (cv_state_reg == CV_SETTLE) begin
        settle_cnt_reg <= settle_cnt_reg - 32'h0000_0001;
      end
      // Forced-on keeps power up even when idle, trading current for start-up delay.
      conv_power <= conv_reg[`FSAC_CONV_ON] | (cv_state_next != CV_OFF);
    end
  end

  // Conversion selections; the sequence is launched by conv_go once power is stable.
  // Cell field values above five are undefined and are passed on unchanged.
  assign conv_go = (cv_state_reg == CV_RUN);
  assign conv_thermistor_sel = conv_reg[5:4];
  assign conv_general_analog_sel = conv_reg[`FSAC_CONV_GENERAL_ANALOG_INPUT];
  assign conv_cell_sel = conv_reg[2:0];

  // Pin drives: open-drain GPIO only ever drives low.
  // The pin is pulled low only while gpio_oe is high; a pull-up lifts it otherwise.
  assign five_volt_regulator_aux = pin_io_reg[`FSAC_IO_AUX];
  assign gpio_out = 1'b0;
  assign gpio_oe = ~pin_io_reg[`FSAC_IO_GPIO_OUT];
  assign sleep_mode = pin_io_reg[`FSAC_IO_SLEEP];
  assign thermistor_ground_switch = pin_io_reg[1:0];

  // Read data is captured in the setup phase and held through the access phase.
  // Unused upper bits read zero for every register.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      if (hit(paddr, `FSAC_IDX_FAULT)) begin
        prdata[5:0] <= fault_reg[5:0];
      end
      if (hit(paddr, `FSAC_IDX_OV_CELLS)) begin
        prdata[CELLS-1:0] <= ov_cells_flags;
      end
      if (hit(paddr, `FSAC_IDX_UV_CELLS)) begin
        prdata[CELLS-1:0] <= uv_cells_flags;
      end
      if (hit(paddr, `FSAC_IDX_PAR_FIRST)) begin
        prdata[7:0] <= parity_first_in;
      end
      if (hit(paddr, `FSAC_IDX_PAR_SEC)) begin
        prdata[3:0] <= parity_second_in;
      end
      if (hit(paddr, `FSAC_IDX_CONV)) begin
        prdata[7:0] <= conv_reg;
      end
      if (hit(paddr, `FSAC_IDX_PIN_IO)) begin
        prdata[7:0] <= {pin_io_reg[7:6], gpio_sync_reg, pin_io_reg[4:0]};
      end
      // The status word is a local view of the sequencer, the power and the comparators.
      if (hit(paddr, `FSAC_IDX_STATUS)) begin
        prdata[5:0] <= {comparators_enable, conv_power, cv_state_reg};
      end
    end
  end

endmodule // fsac_top

// *** logic/fsac_map.vh ***
// Register offsets, field positions, reset values and timing counts for the fault and I/O bank.
`ifndef FSAC_MAP_VH
`define FSAC_MAP_VH
`define FSAC_IDX_FAULT     8'h21
`define FSAC_IDX_OV_CELLS  8'h22
`define FSAC_IDX_UV_CELLS  8'h23
`define FSAC_IDX_PAR_FIRST 8'h24
`define FSAC_IDX_PAR_SEC   8'h25
`define FSAC_IDX_CONV      8'h30
`define FSAC_IDX_PIN_IO    8'h31
`define FSAC_IDX_STATUS    8'h38
`define FSAC_FLT_OV        0
`define FSAC_FLT_UV        1
`define FSAC_FLT_CRC       2
`define FSAC_FLT_POR       3
`define FSAC_FLT_FORCE     4
`define FSAC_FLT_IFAULT    5
`define FSAC_IO_AUX        7
`define FSAC_IO_GPIO_OUT   6
`define FSAC_IO_GPIO_IN    5
`define FSAC_IO_SLEEP      2
`define FSAC_CONV_ON       6
`define FSAC_CONV_GENERAL_ANALOG_INPUT     3
`define FSAC_FAULT_RST     8'h00
`define FSAC_CONV_RST      8'h00
`define FSAC_PIN_IO_RST    8'h40
`define FSAC_CONV_MASK     8'h7f
`define FSAC_PIN_IO_MASK   8'hc7
`define FSAC_WAKE_US       1000
`define FSAC_CLK_MHZ       250
`define FSAC_SETTLE_US     10
`endif

// *** tb/fsac_chk_assertions.sv ***
// Port-level checks for the fault and pin control bank.
`timescale 1ns/1ns
module fsac_chk #(
  parameter int CELLS    = 6,
  parameter int WAKE_CYC = 20
) (
  // Clock, reset and bus.
  input wire             pclk,
  input wire             presetn,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [31:0]      prdata,
  input wire             pslverr,
  // Fault sources and controls.
  input wire [CELLS-1:0] cell_high_flags_in,
  input wire             crc_error_pulse,
  input wire             consistency_fail,
  input wire             comparators_enable,
  input wire             fault_out,
  input wire             conv_go,
  input wire             conv_power,
  input wire [2:0]       conv_cell_sel,
  input wire             gpio_out,
  input wire             gpio_oe,
  input wire             sleep_mode
);
  localparam int WMAX = WAKE_CYC + 4;
  wire wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Packet-error, consistency and high-cell events must reach the fault output within a few cycles.
  crc_fault_a: assert property (crc_error_pulse |-> ##[1:3] fault_out)
    else $error("fault output missed a packet error");
  int_fault_a: assert property (consistency_fail |-> ##[1:3] fault_out)
    else $error("fault output missed a consistency failure");
  high_fault_a: assert property ((|cell_high_flags_in && comparators_enable && !sleep_mode) |-> ##[1:3] fault_out)
    else $error("fault output missed a high cell");
  sleep_cmp_a: assert property (sleep_mode |=> !comparators_enable)
    else $error("comparators still on in sleep");
  // Comparators stay off for at least eight cycles after sleep ends, then return within WMAX cycles.
  wake_delay_a: assert property ($fell(sleep_mode) |-> !comparators_enable [*8] ##[1:WMAX] comparators_enable)
    else $error("wake window wrong");
  go_power_a: assert property (conv_go |-> conv_power)
    else $error("conversion running unpowered");
  upper_zero_a: assert property ((psel && penable && !pwrite) |-> prdata[31:8] == 24'h0000_00)
    else $error("read data upper bits set");
  cell_hold_a: assert property (!wr |=> $stable(conv_cell_sel))
    else $error("cell select changed without a write");
  gpio_hold_a: assert property (!wr |=> $stable(gpio_oe) && !gpio_out)
    else $error("gpio drive changed without a write");
  // Main scenarios reached.
  cover property ($fell(sleep_mode));
  cover property ($rose(conv_go));
  cover property (pslverr);
  cover property ($rose(fault_out));
endmodule // fsac_chk

// *** tb/fsac_far_model.sv ***
// Converter core and GPIO pin standing beyond the bank.
`timescale 1ns/1ns
module fsac_far (
  // Clock.
  input wire  pclk,
  // Converter handshake.
  input wire  conv_go,
  input wire  slow,
  output reg  conv_done,
  // Open-drain pin.
  input wire  gpio_out,
  input wire  gpio_oe,
  output wire gpio_in
);
  reg [4:0] cnt = 5'h0;
  initial conv_done = 1'b0;
  // The pull-up lifts the pin whenever the bank lets go of it.
  assign gpio_in = gpio_oe ? gpio_out : 1'b1;
  // A run ends after a short or long delay; slow mode stresses the wait.
  always @(posedge pclk) begin
    conv_done <= 1'b0;
    if (conv_go && !conv_done) begin
      cnt <= cnt + 5'h1;
      if (cnt == (slow ? 5'hc : 5'h1)) begin
        conv_done <= 1'b1;
        cnt <= 5'h0;
      end
    end else begin
      cnt <= 5'h0;
    end
  end
endmodule // fsac_far

// *** tb/tb_fsac_top.sv ***
// Self-checking bench for the fault and pin control bank.
`timescale 1ns/1ns
module tb_fsac_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic crc_error_pulse = 0, consistency_fail = 0, defaults_loaded = 0, conv_request = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 0, parity_second_in = 0;
  logic [5:0] cell_high_flags_in = 0, cell_low_flags_in = 0;
  logic [7:0] parity_first_in = 0, v;
  wire pready, pslverr, conv_done, conv_power, conv_go, conv_general_analog_sel, fault_out;
  wire five_volt_regulator_aux, gpio_in, gpio_out, gpio_oe, sleep_mode, comparators_enable;
  wire [31:0] prdata;
  wire [1:0] conv_thermistor_sel, thermistor_ground_switch;
  wire [2:0] conv_cell_sel;
  int n_errors = 0, num_checks = 0, n;
  logic [32:0] expq[$];
  fsac_top #(.WAKE_CYC(20), .SETTLE_CYC(5)) dut_u (.*);
  fsac_far far_u (.*);
  // Free-running bus clock.
  initial forever #2 pclk = ~pclk;
  task chk(input logic [32:0] seen, input logic [32:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task guard(input int k);
    if (k >= 100) begin
      n_errors++;
      summarize;
    end
  endtask
  // One transfer; the request is held until pready is seen high.
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0000_00, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 100);
    guard(k);
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    apb(1, i, d, 4'h1);
  endtask
  task rd(input logic [7:0] i, input logic [7:0] d, input logic e = 0);
    expq.push_back({e, 24'h0000_00, d});
    apb(0, i, 8'h00, 4'h0);
  endtask
  // Read answers are compared against the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      chk({pslverr, prdata}, expq.pop_front(), "read");
  end
  initial begin
    void'($urandom(56994));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    defaults_loaded <= 1;
    parity_first_in <= 8'($urandom);
    parity_second_in <= 4'($urandom);
    @(posedge pclk);
    rd(8'h21, 8'h08);
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    wr(8'h24, ~parity_first_in);
    rd(8'h24, parity_first_in);
    rd(8'h25, {4'h0, parity_second_in});
    rd(8'h30, 8'h00);
    rd(8'h31, 8'h60);
    rd(8'h26, 8'h00, 1);
    wr(8'h21, 8'h00);
    rd(8'h21, 8'h08);
    wr(8'h21, 8'h08);
    rd(8'h21, 8'h00);
    for (int k = 0; k < 2; k++) begin
      crc_error_pulse <= (k == 0);
      consistency_fail <= (k == 1);
      @(posedge pclk);
      crc_error_pulse <= 0;
      consistency_fail <= 0;
      rd(8'h21, k ? 8'h20 : 8'h04);
      wr(8'h21, k ? 8'h20 : 8'h04);
      rd(8'h21, 8'h00);
      v = 8'(1 + $urandom % 63);
      if (k) cell_low_flags_in <= v[5:0];
      else cell_high_flags_in <= v[5:0];
      repeat (3) @(posedge pclk);
      cell_low_flags_in <= 0;
      cell_high_flags_in <= 0;
      rd(8'h21, k ? 8'h02 : 8'h01);
      rd(k ? 8'h23 : 8'h22, v);
      wr(8'h21, k ? 8'h02 : 8'h01);
      rd(k ? 8'h23 : 8'h22, 8'h00);
    end
    wr(8'h21, 8'h10);
    rd(8'h21, 8'h10);
    chk(fault_out, 1, "fault_out");
    wr(8'h21, 8'h00);
    rd(8'h21, 8'h00);
    chk(fault_out, 0, "fault_out");
    for (int t = 0; t < 24; t++) begin
      v = {2'b00, 2'(t / 6), 1'($urandom), 3'(t % 6)};
      wr(8'h30, v);
      rd(8'h30, v);
      chk({conv_thermistor_sel, conv_general_analog_sel, conv_cell_sel}, v[5:0], "sel");
    end
    apb(1, 8'h30, 8'h3f, 4'h0);
    rd(8'h30, v);
    wr(8'h31, 8'h83);
    repeat (4) @(posedge pclk);
    rd(8'h31, 8'h83);
    chk({five_volt_regulator_aux, gpio_oe, thermistor_ground_switch}, 4'hf, "pins");
    wr(8'h31, 8'h44);
    cell_high_flags_in <= 6'h3f;
    repeat (3) @(posedge pclk);
    chk(comparators_enable, 0, "cmp");
    cell_high_flags_in <= 0;
    rd(8'h21, 8'h00);
    wr(8'h31, 8'h40);
    n = 0;
    while (comparators_enable !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
    guard(n);
    chk(n >= 20 && n <= 25, 1, "wake");
    rd(8'h31, 8'h60);
    chk({five_volt_regulator_aux, gpio_oe, thermistor_ground_switch}, 4'h0, "pins");
    for (int m = 0; m < 2; m++) begin
      wr(8'h30, m ? 8'h40 : 8'h00);
      slow <= m;
      conv_request <= 1;
      @(posedge pclk);
      conv_request <= 0;
      n = 0;
      while (conv_go !== 1'b1 && n < 100) begin @(posedge pclk); n++; end
      guard(n);
      chk(m ? n <= 2 : n >= 4, 1, "settle");
      n = 0;
      while (conv_go !== 1'b0 && n < 100) begin @(posedge pclk); n++; end
      guard(n);
      repeat (2) @(posedge pclk);
      chk(conv_power, m, "power");
    end
    rd(8'h38, 8'h38);
    summarize;
  end
endmodule // tb_fsac_top
bind fsac_top fsac_chk #(.CELLS(CELLS), .WAKE_CYC(WAKE_CYC)) chk_u (.*);
